/* pkg/io_slot_params.svh */
`ifndef IO_SLOT_PARAMS_SVH
`define IO_SLOT_PARAMS_SVH
// Slot numbers
`define SLOT_BASIC 4'h1
`define SLOT_EXT 4'h2
`define SLOT_HANDWHEEL 4'hf
// Byte counts per slot
`define SLOT_IN_BYTES 6
`define SLOT_OUT_BYTES 4
`define HANDWHEEL_IN_BYTES 3
// Wishbone register byte addresses
`define REG_OUT_DATA_BASIC 8'h00
`define REG_OUT_DATA_EXT 8'h04
`define REG_IN_DATA_BASIC_LO 8'h08
`define REG_IN_DATA_BASIC_HI 8'h0c
`define REG_IN_DATA_EXT_LO 8'h10
`define REG_IN_DATA_EXT_HI 8'h14
`define REG_HANDWHEEL 8'h18
`define REG_CONFIG 8'h1c
`define REG_ALARM_STATUS 8'h20
`define REG_ALARM_ENTRY 8'h24
`define REG_ADDR_MAP 8'h28
// Field positions in alarm entry word
`define ENTRY_DATA_LSB 0
`define ENTRY_BYTE_LSB 8
`define ENTRY_SLOT_LSB 12
`define ENTRY_PATH_LSB 16
`define ENTRY_GROUP_LSB 24
// Reset values
`define CONFIG_RESET 32'h0000_0000
`endif

/* pkg/io_slot_pkg.sv */
package io_slot_pkg;
    typedef logic [7:0] byte_t;
    typedef struct packed {
        logic [7:0] group;
        logic [7:0] path;
        logic [3:0] slot;
        logic [3:0] byte_index;
        logic [7:0] fault_flags;
    } alarm_entry_s;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_SEND = 2'b01,
        SCAN_WAIT = 2'b10
    } scan_state_e;
endpackage

/* pkg/io_link_if.sv */
`timescale 1ns/10ps
interface io_link_if;
    // Output bytes, basic then extension
    logic [31:0] out_basic;
    logic [31:0] out_ext;
    // Input bytes from each module slot
    logic [47:0] in_basic;
    logic [47:0] in_ext;
    logic [23:0] handwheel;
    logic ext_fitted;
    // Status alarm entries from the unit
    logic alarm_valid;
    logic alarm_ready;
    logic [31:0] alarm_entry;
    modport unit (input out_basic, input out_ext, output in_basic, output in_ext, output handwheel,
        output ext_fitted, output alarm_valid, input alarm_ready, output alarm_entry);
    modport ctrl (output out_basic, output out_ext, input in_basic, input in_ext, input handwheel,
        input ext_fitted, input alarm_valid, output alarm_ready, input alarm_entry);
endinterface

/* hw/io_unit.sv */
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "io_slot_params.svh"
module io_unit import io_slot_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link to controller
    io_link_if.unit link,
    // Module strap and identity of connection
    input wire logic ext_fitted_i,
    input wire logic [7:0] group_i,
    input wire logic [7:0] path_i,
    // Field side pins
    input wire logic [47:0] di_basic_i,
    input wire logic [47:0] di_ext_i,
    input wire logic [23:0] handwheel_i,
    input wire logic [7:0] overcurrent_i,
    input wire logic [7:0] overtemp_i,
    input wire logic [63:0] ground_fault_i,
    output logic [63:0] do_o
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, accepted when stages two and three agree
    // A level seen by one stage only is a glitch and never reaches the images
    // The module strap is a pin as well, so it takes the same path
    // Reset clears every stage, so the strap reads absent until it settles
    // Bit map: 200 strap, 199:136 ground, 135:128 heat, 127:120 current, 119:0 data
    logic [200:0] pins;
    logic [200:0] s1_q;
    logic [200:0] s1_d;
    logic [200:0] s2_q;
    logic [200:0] s2_d;
    logic [200:0] s3_q;
    logic [200:0] s3_d;
    logic [200:0] clean_q;
    logic [200:0] clean_d;
    assign pins = {ext_fitted_i, ground_fault_i, overtemp_i, overcurrent_i, handwheel_i, di_ext_i, di_basic_i};
    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
        for (int i = 0; i < 201; i++) begin
            clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            clean_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            clean_q <= clean_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Field views of the filtered pins
    logic [47:0] di_b;
    logic [47:0] di_e;
    logic [23:0] hw_in;
    logic [7:0] oc;
    logic [7:0] ot;
    logic [63:0] gf;
    logic ext_on;
    assign di_b = clean_q[47:0];
    assign di_e = clean_q[95:48];
    assign hw_in = clean_q[119:96];
    assign oc = clean_q[127:120];
    assign ot = clean_q[135:128];
    assign gf = clean_q[199:136];
    assign ext_on = clean_q[200];
    ////////////////////////////////////////////////////////////////////////
    // Slot images: each module owns its own address block
    // An absent extension reads as zero and drives nothing, so slot two stays empty
    logic [47:0] in_b_q;
    logic [47:0] in_b_d;
    logic [47:0] in_e_q;
    logic [47:0] in_e_d;
    logic [23:0] hw_q;
    logic [23:0] hw_d;
    logic [63:0] do_q;
    logic [63:0] do_d;
    always_comb begin
        in_b_d = di_b;
        in_e_d = ext_on ? di_e : 48'h0;
        // Handwheel counts pass straight through as one three-byte slot
        hw_d = hw_in;
        // Whole byte forced off while its driver reports overcurrent or heat;
        // the mask follows the live pins, so the byte returns once the cause is gone
        for (int b = 0; b < 4; b++) begin
            do_d[b*8 +: 8] = (oc[b] | ot[b]) ? 8'h00 : link.out_basic[b*8 +: 8];
            do_d[32+b*8 +: 8] = (oc[4+b] | ot[4+b] | !ext_on) ? 8'h00 : link.out_ext[b*8 +: 8];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_b_q <= '0;
            in_e_q <= '0;
            hw_q <= '0;
            do_q <= '0;
        end else begin
            in_b_q <= in_b_d;
            in_e_q <= in_e_d;
            hw_q <= hw_d;
            do_q <= do_d;
        end
    end
    assign link.in_basic = in_b_q;
    assign link.in_ext = in_e_q;
    assign link.handwheel = hw_q;
    assign link.ext_fitted = ext_on;
    assign do_o = do_q;
    // No alarm or stop output exists; outputs keep running on a ground fault, only an overcurrent or heat byte, or an absent extension, is forced off
    ////////////////////////////////////////////////////////////////////////
    // Status alarm scanner: one entry per output byte whose flags changed
    // Bytes are visited in turn, so a change is reported within one sweep
    // An entry waits in SEND while ready is low, so a slow controller loses none
    scan_state_e st_q;
    scan_state_e st_d;
    logic [2:0] idx_q;
    logic [2:0] idx_d;
    logic [63:0] sent_q;
    logic [63:0] sent_d;
    alarm_entry_s ent_q;
    alarm_entry_s ent_d;
    logic [7:0] flags;
    logic changed;
    logic [3:0] scan_slot;
    logic [3:0] scan_byte;
    // Index bit two picks the module, the low two bits the byte within its slot
    assign scan_slot = idx_q[2] ? `SLOT_EXT : `SLOT_BASIC;
    assign scan_byte = {2'b00, idx_q[1:0]};
    // Ground faults are only reported; they never mask an output byte
    always_comb begin
        flags = gf[idx_q*8 +: 8];
        if (idx_q[2] && !ext_on) begin
            flags = 8'h00;
        end
    end
    assign changed = (flags != sent_q[idx_q*8 +: 8]);
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        sent_d = sent_q;
        ent_d = ent_q;
        unique case (st_q)
            SCAN_IDLE: begin
                if (changed) begin
                    ent_d.group = group_i;
                    ent_d.path = path_i;
                    ent_d.slot = scan_slot;
                    ent_d.byte_index = scan_byte;
                    ent_d.fault_flags = flags;
                    sent_d[idx_q*8 +: 8] = flags;
                    st_d = SCAN_SEND;
                end else begin
                    idx_d = idx_q + 3'd1;
                end
            end
            SCAN_SEND: begin
                if (link.alarm_ready) begin
                    st_d = SCAN_WAIT;
                end
            end
            SCAN_WAIT: begin
                idx_d = idx_q + 3'd1;
                st_d = SCAN_IDLE;
            end
            default: st_d = SCAN_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= SCAN_IDLE;
            idx_q <= 3'd0;
            sent_q <= '0;
            ent_q <= '0;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            sent_q <= sent_d;
            ent_q <= ent_d;
        end
    end
    assign link.alarm_valid = (st_q == SCAN_SEND);
    assign link.alarm_entry = ent_q;
endmodule

/* hw/io_controller.sv */
`timescale 1ns/10ps
`include "io_slot_params.svh"
module io_controller import io_slot_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Link to unit
    io_link_if.ctrl link
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ob_q, ob_d, oe_q, oe_d, rd_q, rd_d;
    logic ack_q, ack_d;
    logic [63:0] flags_q, flags_d;
    alarm_entry_s last_q, last_d;
    logic cnt_new_q, cnt_new_d;
    logic req;
    logic wr_take;
    logic [31:0] wmask;
    assign req = cyc_i && stb_i && !ack_q;
    // Writes land at the edge that sees ack high, with address and data still held
    assign wr_take = cyc_i && stb_i && we_i && ack_q;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    always_comb begin
        ob_d = ob_q;
        oe_d = oe_q;
        rd_d = 32'h0;
        ack_d = req;
        flags_d = flags_q;
        last_d = last_q;
        cnt_new_d = cnt_new_q;
        if (wr_take) begin
            unique case (adr_i)
                `REG_OUT_DATA_BASIC: ob_d = (ob_q & ~wmask) | (dat_i & wmask);
                `REG_OUT_DATA_EXT: oe_d = (oe_q & ~wmask) | (dat_i & wmask);
                default: ;
            endcase
        end
        if (req && !we_i) begin
            // Handwheel slot is not mapped for reads: the link consumes it directly
            unique case (adr_i)
                `REG_OUT_DATA_BASIC: rd_d = ob_q;
                `REG_OUT_DATA_EXT: rd_d = oe_q;
                `REG_IN_DATA_BASIC_LO: rd_d = link.in_basic[31:0];
                `REG_IN_DATA_BASIC_HI: rd_d = {16'h0, link.in_basic[47:32]};
                `REG_IN_DATA_EXT_LO: rd_d = link.in_ext[31:0];
                `REG_IN_DATA_EXT_HI: rd_d = {16'h0, link.in_ext[47:32]};
                `REG_HANDWHEEL: rd_d = 32'h0;
                `REG_CONFIG: rd_d = {31'h0, link.ext_fitted};
                `REG_ALARM_STATUS: rd_d = flags_q[31:0] | flags_q[63:32];
                `REG_ALARM_ENTRY: rd_d = {cnt_new_q, last_q[30:0]};
                `REG_ADDR_MAP: rd_d = 32'h0;
                default: rd_d = 32'h0;
            endcase
            if (adr_i == `REG_ALARM_ENTRY) begin
                cnt_new_d = 1'b0;
            end
        end
        if (link.alarm_valid) begin
            last_d = link.alarm_entry;
            cnt_new_d = 1'b1;
            flags_d[{link.alarm_entry[`ENTRY_SLOT_LSB + 1], link.alarm_entry[`ENTRY_BYTE_LSB +: 2], 3'b000} +: 8] =
                link.alarm_entry[7:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ob_q <= '0;
            oe_q <= '0;
            rd_q <= '0;
            ack_q <= 1'b0;
            flags_q <= '0;
            last_q <= '0;
            cnt_new_q <= 1'b0;
        end else begin
            ob_q <= ob_d;
            oe_q <= oe_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
            flags_q <= flags_d;
            last_q <= last_d;
            cnt_new_q <= cnt_new_d;
        end
    end
    assign dat_o = rd_q;
    assign ack_o = ack_q;
    assign link.out_basic = ob_q;
    assign link.out_ext = oe_q;
    assign link.alarm_ready = 1'b1;
endmodule

/* testbench/io_link_sva.sv */
`timescale 1ns/10ps
module io_link_sva #(parameter logic [7:0] GRP = 8'h15, parameter logic [7:0] PTH = 8'h03) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic [31:0] out_basic,
    input wire logic [31:0] out_ext,
    input wire logic ext_fitted,
    input wire logic alarm_valid,
    input wire logic alarm_ready,
    input wire logic [31:0] alarm_entry
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_entry; alarm_valid; endsequence
    sequence s_quiet; !alarm_valid; endsequence
    property p_pulse; s_entry |=> s_quiet; endproperty
    property p_ready; s_entry |-> alarm_ready; endproperty
    property p_slot; s_entry |-> alarm_entry[15:12] inside {4'h1, 4'h2}; endproperty
    property p_byte; s_entry |-> alarm_entry[11:8] <= 4'h3; endproperty
    property p_group; s_entry |-> alarm_entry[31:24] == GRP; endproperty
    property p_path; s_entry |-> alarm_entry[23:16] == PTH; endproperty
    property p_ext; alarm_valid && alarm_entry[15:12] == 4'h2 |-> ext_fitted; endproperty
    // Outputs come up quiet so no stale alarm is seen
    property p_rst; $fell(rst_i) |-> !alarm_valid && out_basic == 32'h0 && out_ext == 32'h0; endproperty
    a_pulse: assert property (p_pulse) else $error("alarm valid held");
    a_ready: assert property (p_ready) else $error("alarm not accepted");
    a_slot: assert property (p_slot) else $error("bad slot");
    a_byte: assert property (p_byte) else $error("bad byte index");
    a_group: assert property (p_group) else $error("bad group");
    a_path: assert property (p_path) else $error("bad path");
    a_ext: assert property (p_ext) else $error("slot two without module");
    a_rst: assert property (p_rst) else $error("outputs not idle");
endmodule

/* testbench/test_io_slot_map_and_output_fault_status.sv */
`timescale 1ns/10ps
`include "io_slot_params.svh"
module test_io_slot_map_and_output_fault_status;
    localparam logic [7:0] GRP = 8'h15;
    localparam logic [7:0] PTH = 8'h03;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack_o;
    logic [47:0] di_b = 48'h0;
    logic [47:0] di_e = 48'h0;
    logic [23:0] hw = 24'h0;
    logic [7:0] oc = 8'h00;
    logic [7:0] ot = 8'h00;
    logic [63:0] gf = 64'h0;
    logic ext_fit = 1'b1;
    logic [63:0] do_o;
    int n_mismatch = 0;
    int total_checks = 0;
    always #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////
    io_link_if u_io_link_if ();
    io_unit u_io_unit (.clk_i(clk_i), .rst_i(rst_i), .link(u_io_link_if.unit), .ext_fitted_i(ext_fit),
        .group_i(GRP), .path_i(PTH), .di_basic_i(di_b), .di_ext_i(di_e), .handwheel_i(hw),
        .overcurrent_i(oc), .overtemp_i(ot), .ground_fault_i(gf), .do_o(do_o));
    io_controller u_io_controller (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .link(u_io_link_if.ctrl));
    io_link_sva #(.GRP(GRP), .PTH(PTH)) u_io_link_sva (.clk_i(clk_i), .rst_i(rst_i),
        .out_basic(u_io_link_if.out_basic), .out_ext(u_io_link_if.out_ext), .ext_fitted(u_io_link_if.ext_fitted),
        .alarm_valid(u_io_link_if.alarm_valid), .alarm_ready(u_io_link_if.alarm_ready),
        .alarm_entry(u_io_link_if.alarm_entry));
    ////////////////////////////////////////////////////////////////
    task automatic settle(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            $display("MISMATCH wb ack expected 1 seen 0");
        end
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 4'hf, 32'h0);
        chk(nm, {32'h0, e}, {32'h0, rd});
    endtask
    // Scanner latency is not fixed, so wait on the entry strobe itself
    task automatic wait_alarm;
        int n;
        n = 0;
        while (u_io_link_if.alarm_valid !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            $display("MISMATCH alarm valid expected 1 seen 0");
        end
        settle(2);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #800000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        settle(20);
        rst_i <= 1'b0;
        di_b <= 48'h1122_3344_5566;
        di_e <= 48'hab98_7654_3210;
        hw <= 24'h5a3c81;
        settle(8);
        rdchk("config", `REG_CONFIG, 32'h1);
        rdchk("basic lo", `REG_IN_DATA_BASIC_LO, 32'h3344_5566);
        rdchk("basic hi", `REG_IN_DATA_BASIC_HI, 32'h1122);
        rdchk("ext lo", `REG_IN_DATA_EXT_LO, 32'h7654_3210);
        rdchk("ext hi", `REG_IN_DATA_EXT_HI, 32'hab98);
        rdchk("handwheel reg", `REG_HANDWHEEL, 32'h0);
        rdchk("unmapped", 8'h3c, 32'h0);
        chk("handwheel link", 64'h5a3c81, {40'h0, u_io_link_if.handwheel});
        $display("test map done");
        wb(1'b1, `REG_OUT_DATA_BASIC, 4'hf, 32'ha5c3_0f18);
        wb(1'b1, `REG_OUT_DATA_BASIC, 4'h4, 32'h0077_0000);
        wb(1'b1, `REG_OUT_DATA_EXT, 4'hf, 32'h1234_5678);
        settle(8);
        chk("do", 64'h1234_5678_a577_0f18, do_o);
        oc <= 8'h02;
        ot <= 8'h20;
        settle(8);
        chk("do forced", 64'h1234_0078_a577_0018, do_o);
        rdchk("status quiet", `REG_ALARM_STATUS, 32'h0);
        oc <= 8'h00;
        ot <= 8'h00;
        settle(8);
        chk("do restored", 64'h1234_5678_a577_0f18, do_o);
        ext_fit <= 1'b0;
        settle(8);
        rdchk("config absent", `REG_CONFIG, 32'h0);
        rdchk("ext lo absent", `REG_IN_DATA_EXT_LO, 32'h0);
        chk("do absent", 64'h0000_0000_a577_0f18, do_o);
        ext_fit <= 1'b1;
        settle(8);
        $display("test outputs done");
        gf <= 64'h0000_0000_0000_0200;
        wait_alarm();
        rdchk("entry basic", `REG_ALARM_ENTRY, {1'b1, GRP[6:0], PTH, 4'h1, 4'h1, 8'h02});
        rdchk("entry read", `REG_ALARM_ENTRY, {GRP, PTH, 4'h1, 4'h1, 8'h02});
        gf <= 64'h0000_0010_0000_0200;
        wait_alarm();
        rdchk("entry ext", `REG_ALARM_ENTRY, {1'b1, GRP[6:0], PTH, 4'h2, 4'h0, 8'h10});
        rdchk("status", `REG_ALARM_STATUS, 32'h0000_0210);
        chk("do kept", 64'h1234_5678_a577_0f18, do_o);
        $display("test faults done");
        end_sim();
    end
endmodule
